// ==== testbench/sdcs_spacing_sva.sv ====
/*
  Checker for the pin bundle between controller and registered module.
  Assumes one clk_sys domain, srst synchronous high, CAS latency 3 grade.
*/
`timescale 1ns/1ps
module sdcs_spacing_sva
  import sdcs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Pins
  input wire logic cke,
  input wire sdcs_pkg::sdcs_cmd_e cmd,
  input wire logic [sdcs_pkg::A_W-1:0] a,
  input wire logic [sdcs_pkg::DQ_W/sdcs_pkg::LANE_W-1:0] dqm,
  input wire logic dq_c_oe,
  input wire logic [sdcs_pkg::DQ_W/sdcs_pkg::LANE_W-1:0] dq_d_oe
);
  logic [10:0] up_q;
  logic [1:0] refs_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // Cycles since reset release, saturating so a long run never wraps.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      up_q <= 11'h000;
    end else if (up_q != 11'h7ff) begin
      up_q <= up_q + 11'h001;
    end
  end

  // Wake-up refreshes seen since reset; only the first two matter.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      refs_q <= 2'h0;
    end else if (cke && cmd == CMD_REF && refs_q != 2'h2) begin
      refs_q <= refs_q + 2'h1;
    end
  end

  powerup_wait_a: assert property (cmd != CMD_NOP |-> up_q >= POWERUP_CYC - 2)
    else $error("command issued before the power-up pause ended");
  wake_refresh_a: assert property (cmd == CMD_ACT |-> refs_q == 2'h2)
    else $error("row opened before two wake-up refreshes");
  wr_data_a: assert property (cke && cmd == CMD_WR |-> dq_c_oe)
    else $error("write data not driven with the write command");
  wr_to_pre_a: assert property (cke && cmd == CMD_WR |=> cmd != CMD_PRE)
    else $error("precharge too close to write data");
  lmr_gap_a: assert property (cmd == CMD_LMR |=> (cmd != CMD_ACT && cmd != CMD_REF) [*2])
    else $error("activate or refresh too soon after mode load");
  cke_lead_a: assert property ($rose(cke) |-> cmd == CMD_NOP)
    else $error("command on the clock that re-enables the module");
  cke_idle_a: assert property (!cke |-> cmd == CMD_NOP)
    else $error("command issued while clock enable is low");
  rd_data_a: assert property (cke && cmd == CMD_RD |-> ##4 dq_d_oe == '1)
    else $error("read data not on lanes four clocks after read");
  rd_stray_a: assert property (dq_d_oe != '0 |-> $past(cmd, 4) == CMD_RD)
    else $error("module drives lanes with no read behind them");
  // Write masks ride with write data, so only the module driving counts as a clash.
  bus_clash_a: assert property (dq_c_oe |-> dq_d_oe == '0)
    else $error("both ends drive the data lanes");
  mask_write_a: assert property (dqm != '0 |-> dq_c_oe)
    else $error("byte mask raised without write data");
  bst_gap_a: assert property (cmd == CMD_BST |-> !dq_c_oe)
    else $error("burst stop on the clock of write data");
endmodule // sdcs_spacing_sva

// ==== testbench/sdram_command_spacing_tb.sv ====
/*
  Self-checking bench: controller and registered module face each other.
  Assumes 10 MHz clk_sys, CAS latency 3 grade, short refresh period of 400.
*/
`timescale 1ns/1ps
module sdram_command_spacing_tb;
  import sdcs_pkg::*;
  localparam int AW = BA_W + A_W + 8;
  logic clk_sys, srst, req_valid, req_we, req_ready, pd_req, pd_active;
  logic rd_valid, init_done, dev_init_done, powered_down;
  logic [AW-1:0] req_addr;
  logic [DQ_W-1:0] req_wdata, rd_data;
  logic [7:0] req_mask;
  logic [2:0] cas_latency;
  logic [DQ_W-1:0] model [0:63];
  logic [DQ_W-1:0] rd_q[$];
  logic [DQ_W-1:0] exp_q[$];
  int fails, tests_run, refusals, ref_seen, base;

  sdcs_if sdcs_if_inst ();
  sdcs_ctrl #(.REF_PERIOD_CYCLES(400)) sdcs_ctrl_inst (.clk_sys(clk_sys), .srst(srst),
    .bus(sdcs_if_inst), .req_valid(req_valid), .req_ready(req_ready), .req_we(req_we),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_mask(req_mask), .rd_valid(rd_valid),
    .rd_data(rd_data), .pd_req(pd_req), .pd_active(pd_active), .init_done(init_done));
  sdcs_dev sdcs_dev_inst (.clk_sys(clk_sys), .srst(srst), .bus(sdcs_if_inst),
    .init_done(dev_init_done), .cas_latency(cas_latency), .powered_down(powered_down));
  sdcs_spacing_sva sdcs_spacing_sva_inst (.clk_sys(clk_sys), .srst(srst),
    .cke(sdcs_if_inst.cke), .cmd(sdcs_if_inst.cmd), .a(sdcs_if_inst.a),
    .dqm(sdcs_if_inst.dqm), .dq_c_oe(sdcs_if_inst.dq_c_oe), .dq_d_oe(sdcs_if_inst.dq_d_oe));

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  end

  // Collect returned words and count refreshes that reach the module.
  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (sdcs_if_inst.cke === 1'b1 && sdcs_if_inst.cmd === CMD_REF) ref_seen++;
  end

  task automatic summarize();
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %0t %s: got %h expected %h", $time, m, got, exp);
      fails++;
    end
  endtask

  task automatic timeout(input string m);
    $display("ERROR %0t timed out waiting for %s", $time, m);
    fails++;
    summarize();
  endtask

  // Bounded wait on a level; sampled at the falling edge, away from updates.
  task automatic wait_on(ref logic f, input logic v, input int lim, input string m);
    int n;
    n = 0;
    while (f !== v) begin
      @(negedge clk_sys);
      n++;
      if (n > lim) timeout(m);
    end
    @(posedge clk_sys);
  endtask

  // Holds the request until an edge where ready is high; caller releases.
  task automatic push(input logic we, input int idx, input logic [DQ_W-1:0] d,
                      input logic [7:0] m);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_we <= we;
    req_addr <= {2'(idx >> 4), 12'(idx >> 4), 8'(idx & 15)};
    req_wdata <= d;
    req_mask <= m;
    @(negedge clk_sys);
    while (req_ready !== 1'b1) begin
      refusals++;
      n++;
      if (n > 3000) timeout("request slot");
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
  endtask

  // Model keeps lanes whose mask bit is high, as the module must.
  task automatic wr(input int idx, input logic [DQ_W-1:0] d, input logic [7:0] m);
    for (int l = 0; l < 8; l++) begin
      if (!m[l]) model[idx][l*8 +: 8] = d[l*8 +: 8];
    end
    push(1'b1, idx, d, m);
  endtask

  task automatic rd(input int idx);
    exp_q.push_back(model[idx]);
    push(1'b0, idx, '0, 8'h00);
  endtask

  // Releases the request line, then compares returns in issue order.
  task automatic drain();
    int n;
    n = 0;
    req_valid <= 1'b0;
    while (rd_q.size() < exp_q.size()) begin
      @(negedge clk_sys);
      n++;
      if (n > 2000) timeout("read data");
    end
    while (exp_q.size() > 0) check(rd_q.pop_front(), exp_q.pop_front(), "read data");
    @(posedge clk_sys);
  endtask

  // Main sequence.
  initial begin
    srst = 1'b1;
    req_valid = 1'b0;
    req_we = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    req_mask = 8'h00;
    pd_req = 1'b0;
    fails = 0;
    tests_run = 0;
    refusals = 0;
    ref_seen = 0;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    wait_on(init_done, 1'b1, 3000, "init");
    // The module counts the refreshes a register later than the controller sends them.
    repeat (3) @(posedge clk_sys);
    check(64'(dev_init_done), 64'h1, "module wake-up");
    check(64'(cas_latency), 64'h3, "cas latency");
    // Writes over all four banks; same-row pairs leave on adjacent clocks.
    for (int i = 0; i < 6; i++) wr(i * 11, {16{4'(i + 1)}}, 8'h00);
    wr(11, 64'hffff_ffff_ffff_ffff, 8'h0f);
    for (int i = 0; i < 6; i++) rd(i * 11);
    drain();
    check(64'(refusals > 0), 64'h1, "buffer never refused");
    // Write then read the same word with no gap between requests.
    wr(4, 64'h0f0f_a5a5_5a5a_f0f0, 8'h81);
    rd(4);
    drain();
    // Long power-down overruns refresh; two refreshes must follow exit.
    pd_req <= 1'b1;
    wait_on(pd_active, 1'b1, 200, "power-down");
    repeat (2) @(posedge clk_sys);
    check(64'(sdcs_if_inst.cke), 64'h0, "clock enable in power-down");
    check(64'(powered_down), 64'h1, "module power-down");
    repeat (450) @(posedge clk_sys);
    base = ref_seen;
    pd_req <= 1'b0;
    wait_on(pd_active, 1'b0, 50, "power-up");
    // Short window, so a timer refresh alone cannot make up the pair.
    repeat (20) @(posedge clk_sys);
    check(64'(ref_seen - base >= 2), 64'h1, "refreshes after overrun");
    rd(11);
    rd(55);
    drain();
    summarize();
  end
endmodule // sdram_command_spacing_tb

// ==== verilog/sdcs_ctrl.sv ====
/*
  Memory controller end: power-up sequence, refresh timer, two-entry request
  buffer, closed-page command scheduler, power-down and read return capture.
  Assumes one registered SDRAM module on the same clk_sys.
*/
`timescale 1ns/1ps
module sdcs_ctrl #(
  parameter sdcs_pkg::sdcs_grade_e GRADE = sdcs_pkg::CL3_GRADE,
  parameter bit AUTO_PRE = 1'b0,
  parameter int DQ_W = sdcs_pkg::DQ_W,
  parameter int COL_W = 8,
  parameter int REF_PERIOD_CYCLES = sdcs_pkg::REF_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Pins
  sdcs_if.ctrl bus,
  // Request stream
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_we,
  input wire logic [sdcs_pkg::BA_W+sdcs_pkg::A_W+COL_W-1:0] req_addr,
  input wire logic [DQ_W-1:0] req_wdata,
  input wire logic [DQ_W/sdcs_pkg::LANE_W-1:0] req_mask,
  // Read return
  output logic rd_valid,
  output logic [DQ_W-1:0] rd_data,
  // Power and status
  input wire logic pd_req,
  output logic pd_active,
  output logic init_done
);
  import sdcs_pkg::*;
  localparam int LANES = DQ_W / LANE_W;
  localparam int CL = grade_cl(GRADE);
  localparam int RET = REG_LATENCY + CL;
  localparam int AW = BA_W + A_W + COL_W;

  if (DQ_W % LANE_W != 0 || COL_W > AP_BIT || REF_PERIOD_CYCLES <= REF_INT_CYC
      || REF_PERIOD_CYCLES >= 2**24) begin : g_bad_param
    $error("sdcs_ctrl: unsupported parameter values");
  end

  typedef enum logic [7:0] {
    ST_PWRUP = 8'h01, ST_REF = 8'h02, ST_LMR = 8'h04, ST_IDLE = 8'h08,
    ST_COL = 8'h10, ST_RECOV = 8'h20, ST_PDOWN = 8'h40, ST_ACT = 8'h80
  } sdcs_state_e;

  sdcs_state_e st_q;
  logic [15:0] wait_q;
  logic [1:0] refs_left_q;
  logic [11:0] ref_tmr_q;
  logic ref_due_q;
  logic [23:0] ref_age_q;
  logic overdue;
  logic ent_we [2];
  logic [AW-1:0] ent_addr [2];
  logic [DQ_W-1:0] ent_data [2];
  logic [LANES-1:0] ent_mask [2];
  logic wp_q, rp_q;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop, chain, issue_ref;
  logic [RET:0] rd_pipe_q;
  logic cke_q, dq_oe_q, rd_valid_q, init_done_q, ready_q;
  logic pd_q;
  sdcs_cmd_e cmd_q;
  logic [BA_W-1:0] ba_q;
  logic [A_W-1:0] a_q;
  logic [LANES-1:0] dqm_q;
  logic [DQ_W-1:0] dq_q, rd_data_q;

  // Spacing counters load the gap minus one; zero means the next command may go.
  function automatic logic [15:0] gap(input int n);
    return 16'(n - 1);
  endfunction

  function automatic logic [BA_W-1:0] bank_of(input logic [AW-1:0] ad);
    return ad[AW-1 -: BA_W];
  endfunction

  function automatic logic [A_W-1:0] row_of(input logic [AW-1:0] ad);
    return ad[COL_W +: A_W];
  endfunction

  // Buffer handshakes; a chained access needs the second entry on the open row.
  always_comb begin
    push = req_valid && ready_q;
    pop = (st_q == ST_COL) && (wait_q == 16'h0) && (cnt_q != 2'h0)
          && !(ent_we[rp_q] && rd_pipe_q != '0);
    chain = (cnt_q == 2'h2) && (ent_we[~rp_q] == ent_we[rp_q])
            && (ent_addr[~rp_q][AW-1:COL_W] == ent_addr[rp_q][AW-1:COL_W]);
    cnt_d = cnt_q + 2'(push) - 2'(pop);
    overdue = (ref_age_q >= 24'(REF_PERIOD_CYCLES));
    issue_ref = (st_q == ST_REF) && (wait_q == 16'h0);
  end

  // Two-entry request buffer; ready drops when full so the source stalls.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
      ready_q <= 1'b0;
    end else begin
      if (push) begin
        ent_we[wp_q] <= req_we;
        ent_addr[wp_q] <= req_addr;
        ent_data[wp_q] <= req_wdata;
        ent_mask[wp_q] <= req_mask;
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != 2'h2);
    end
  end

  // Refresh timer; the due flag sets over a clear in the same clock.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ref_tmr_q <= 12'h0;
      ref_due_q <= 1'b0;
      ref_age_q <= 24'h0;
    end else begin
      ref_tmr_q <= (ref_tmr_q == 12'(REF_INT_CYC - 1)) ? 12'h0 : ref_tmr_q + 12'h1;
      if (ref_tmr_q == 12'(REF_INT_CYC - 1)) begin
        ref_due_q <= 1'b1;
      end else if (issue_ref) begin
        ref_due_q <= 1'b0;
      end
      if (issue_ref) begin
        ref_age_q <= 24'h0;
      end else if (!overdue) begin
        ref_age_q <= ref_age_q + 24'h1;
      end
    end
  end

  // Read return: data shows RET clocks after the command leaves, one more
  // because the register in the module delays the command.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_pipe_q <= '0;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      rd_pipe_q <= {rd_pipe_q[RET-1:0], pop && !ent_we[rp_q]};
      rd_valid_q <= rd_pipe_q[RET];
      if (rd_pipe_q[RET]) begin
        rd_data_q <= bus.dq;
      end
    end
  end

  // Scheduler. The clock never stops here, only clock enable drops.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= ST_PWRUP;
      wait_q <= gap(POWERUP_CYC);
      refs_left_q <= 2'(WAKE_REFRESHES);
      init_done_q <= 1'b0;
      cke_q <= 1'b1;
      pd_q <= 1'b0;
      cmd_q <= CMD_NOP;
      ba_q <= '0;
      a_q <= '0;
      dqm_q <= '0;
      dq_q <= '0;
      dq_oe_q <= 1'b0;
    end else begin
      // Burst length is one, so burst stop never follows write data.
      cmd_q <= CMD_NOP;
      dq_oe_q <= 1'b0;
      dqm_q <= '0;
      if (wait_q != 16'h0) begin
        wait_q <= wait_q - 16'h1;
      end
      case (st_q)
        ST_PWRUP: begin
          if (wait_q == 16'h0) begin
            cmd_q <= CMD_PRE;
            a_q <= A_W'(1) << AP_BIT;
            wait_q <= gap(RP_CYC);
            st_q <= ST_REF;
          end
        end
        ST_REF: begin
          if (wait_q == 16'h0) begin
            cmd_q <= CMD_REF;
            wait_q <= gap(RFC_CYC);
            refs_left_q <= refs_left_q - 2'h1;
            if (refs_left_q == 2'h1) begin
              st_q <= init_done_q ? ST_IDLE : ST_LMR;
            end
          end
        end
        ST_LMR: begin
          if (wait_q == 16'h0) begin
            cmd_q <= CMD_LMR;
            a_q <= A_W'(CL) << MR_CL_LSB;
            wait_q <= gap(LMR_GAP_SAFE);
            init_done_q <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (wait_q == 16'h0) begin
            if (ref_due_q || overdue) begin
              refs_left_q <= overdue ? 2'(WAKE_REFRESHES) : 2'h1;
              st_q <= ST_REF;
            end else if (pd_req) begin
              cke_q <= 1'b0;
              pd_q <= 1'b1;
              st_q <= ST_PDOWN;
            end else if (cnt_q != 2'h0) begin
              st_q <= ST_ACT;
            end
          end
        end
        ST_ACT: begin
          cmd_q <= CMD_ACT;
          ba_q <= bank_of(ent_addr[rp_q]);
          a_q <= row_of(ent_addr[rp_q]);
          wait_q <= gap(RCD_CYC);
          st_q <= ST_COL;
        end
        ST_COL: begin
          if (pop) begin
            cmd_q <= ent_we[rp_q] ? CMD_WR : CMD_RD;
            a_q <= A_W'(ent_addr[rp_q][COL_W-1:0]);
            if (ent_we[rp_q]) begin
              dq_q <= ent_data[rp_q];
              dqm_q <= ent_mask[rp_q];
              dq_oe_q <= 1'b1;
            end
            if (chain) begin
              wait_q <= gap(COLUMN_CMD_SPACING);
            end else if (ent_we[rp_q] && AUTO_PRE) begin
              a_q[AP_BIT] <= 1'b1;
              wait_q <= gap(write_data_to_activate(GRADE) + 1);
              st_q <= ST_IDLE;
            end else begin
              wait_q <= gap(ent_we[rp_q] ? DATA_TO_PRECHARGE : 1);
              st_q <= ST_RECOV;
            end
          end
        end
        ST_RECOV: begin
          if (wait_q == 16'h0) begin
            cmd_q <= CMD_PRE;
            a_q <= '0;
            wait_q <= gap(RP_CYC);
            st_q <= ST_IDLE;
          end
        end
        ST_PDOWN: begin
          if (!pd_req) begin
            cke_q <= 1'b1;
            pd_q <= 1'b0;
            wait_q <= gap(POWERDOWN_EXIT_LEAD + 1);
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign bus.cke = cke_q;
  assign bus.cmd = cmd_q;
  assign bus.ba = ba_q;
  assign bus.a = a_q;
  assign bus.dqm = dqm_q;
  assign bus.dq_c = dq_q;
  assign bus.dq_c_oe = dq_oe_q;
  assign req_ready = ready_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign init_done = init_done_q;
  assign pd_active = pd_q;

endmodule // sdcs_ctrl

// ==== verilog/sdcs_dev.sv ====
/*
  Registered SDRAM module end: input register, mode register, burst engine,
  small data array and read output pipeline with lane masking.
  Assumes the controller keeps all command spacing on the shared clock.
*/
`timescale 1ns/1ps
module sdcs_dev #(
  parameter int DQ_W = sdcs_pkg::DQ_W,
  parameter int MEM_AW = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Pins
  sdcs_if.dev bus,
  // Status
  output logic init_done,
  output logic [2:0] cas_latency,
  output logic powered_down
);
  import sdcs_pkg::*;
  localparam int LANES = DQ_W / LANE_W;
  localparam int COL_AW = MEM_AW - BA_W;

  if (DQ_W % LANE_W != 0 || MEM_AW <= BA_W) begin : g_bad_param
    $error("sdcs_dev: unsupported width or depth");
  end

  logic cke_q;
  sdcs_cmd_e cmd_q;
  sdcs_cmd_e cmd;
  logic [BA_W-1:0] ba_q;
  logic [A_W-1:0] a_q;
  logic [LANES-1:0] dqm_q;
  logic [DQ_W-1:0] din_q;
  logic [2:0] cl_q;
  logic [3:0] bl_q;
  logic [1:0] refs_q;
  logic rd_mode_q, wr_mode_q;
  logic [3:0] left_q;
  logic [COL_AW-1:0] col_q;
  logic [BA_W-1:0] bk_q;
  logic beat_rd, beat_wr;
  logic [MEM_AW-1:0] beat_addr;
  logic [DQ_W-1:0] mem [2**MEM_AW];
  logic [1:0] rsh_v_q;
  logic [DQ_W-1:0] rsh_d0_q, rsh_d1_q;
  logic [LANES-1:0] mask_d1_q;
  logic [DQ_W-1:0] dq_d_q;
  logic [LANES-1:0] dq_oe_q;
  logic done_q, pd_q;

  function automatic logic [3:0] burst_beats(input logic [2:0] code);
    return (code > 3'h3) ? 4'h8 : 4'(1 << code);
  endfunction

  // Every pin passes one register, which adds a clock to all timing.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cke_q <= 1'b0;
      cmd_q <= CMD_NOP;
      ba_q <= '0;
      a_q <= '0;
      dqm_q <= '0;
      din_q <= '0;
      pd_q <= 1'b1;
    end else begin
      cke_q <= bus.cke;
      pd_q <= ~bus.cke; // Status flop tracks the same registered clock enable.
      cmd_q <= bus.cmd;
      ba_q <= bus.ba;
      a_q <= bus.a;
      dqm_q <= bus.dqm;
      din_q <= bus.dq;
    end
  end

  // A low clock enable suspends the part, so commands are ignored.
  always_comb begin
    cmd = cke_q ? cmd_q : CMD_NOP;
  end

  // Mode register and wake-up refresh count.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cl_q <= 3'h3;
      bl_q <= 4'h1;
      refs_q <= 2'h0;
      done_q <= 1'b0;
    end else begin
      // The status flop trails the count by a clock so the pin comes from a register.
      done_q <= (refs_q == 2'(WAKE_REFRESHES));
      if (cmd == CMD_LMR) begin
        cl_q <= (a_q[MR_CL_LSB +: 3] == 3'h2) ? 3'h2 : 3'h3;
        bl_q <= burst_beats(a_q[MR_BL_LSB +: 3]);
      end
      if (cmd == CMD_REF && refs_q != 2'(WAKE_REFRESHES)) begin
        refs_q <= refs_q + 2'h1;
      end
    end
  end

  // A new column command is taken on any clock and cuts the running burst.
  always_comb begin
    beat_rd = 1'b0;
    beat_wr = 1'b0;
    beat_addr = {bk_q, col_q};
    if (cmd == CMD_RD || cmd == CMD_WR) begin
      beat_rd = (cmd == CMD_RD);
      beat_wr = (cmd == CMD_WR);
      beat_addr = {ba_q, a_q[COL_AW-1:0]};
    end else if (cke_q && cmd != CMD_PRE && cmd != CMD_BST && left_q != 4'h0) begin
      beat_rd = rd_mode_q;
      beat_wr = wr_mode_q;
    end
  end

  // Burst counter; precharge and burst stop end the remaining beats.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_mode_q <= 1'b0;
      wr_mode_q <= 1'b0;
      left_q <= 4'h0;
      col_q <= '0;
      bk_q <= '0;
    end else if (cke_q) begin
      if (cmd == CMD_RD || cmd == CMD_WR) begin
        rd_mode_q <= (cmd == CMD_RD);
        wr_mode_q <= (cmd == CMD_WR);
        left_q <= bl_q - 4'h1;
        col_q <= a_q[COL_AW-1:0] + COL_AW'(1);
        bk_q <= ba_q;
      end else if (cmd == CMD_PRE || cmd == CMD_BST) begin
        left_q <= 4'h0;
      end else if (left_q != 4'h0) begin
        left_q <= left_q - 4'h1;
        col_q <= col_q + COL_AW'(1);
      end
    end
  end

  // Write data is taken with the mask of the same clock; masked lanes keep old data.
  always_ff @(posedge clk_sys) begin
    if (beat_wr) begin
      for (int l = 0; l < LANES; l++) begin
        if (!dqm_q[l]) begin
          mem[beat_addr][l*LANE_W +: LANE_W] <= din_q[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Read pipeline; the tap chosen by CAS latency sets when data reaches the pins.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsh_v_q <= 2'h0;
      rsh_d0_q <= '0;
      rsh_d1_q <= '0;
      mask_d1_q <= '0;
      dq_d_q <= '0;
      dq_oe_q <= '0;
    end else begin
      rsh_v_q <= {rsh_v_q[0], beat_rd};
      rsh_d0_q <= mem[beat_addr];
      rsh_d1_q <= rsh_d0_q;
      mask_d1_q <= dqm_q;
      dq_d_q <= (cl_q == 3'h3) ? rsh_d1_q : rsh_d0_q;
      // Lanes masked two clocks earlier float; stopped beats never drive.
      dq_oe_q <= {LANES{(cl_q == 3'h3) ? rsh_v_q[1] : rsh_v_q[0]}} & ~mask_d1_q;
    end
  end

  assign bus.dq_d = dq_d_q;
  assign bus.dq_d_oe = dq_oe_q;
  // Every status output is taken straight from a flop.
  assign init_done = done_q;
  assign cas_latency = cl_q;
  assign powered_down = pd_q;

endmodule // sdcs_dev

// ==== verilog/sdcs_if.sv ====
/*
  Pin bundle between the memory controller and the registered module.
  Assumes both ends share clk_sys; the shared data lanes are resolved here.
*/
`timescale 1ns/1ps
interface sdcs_if #(
  parameter int DQ_W = sdcs_pkg::DQ_W
);
  localparam int LANES = DQ_W / sdcs_pkg::LANE_W;
  logic cke;
  sdcs_pkg::sdcs_cmd_e cmd;
  logic [sdcs_pkg::BA_W-1:0] ba;
  logic [sdcs_pkg::A_W-1:0] a;
  logic [LANES-1:0] dqm;
  logic [DQ_W-1:0] dq_c;
  logic dq_c_oe;
  logic [DQ_W-1:0] dq_d;
  logic [LANES-1:0] dq_d_oe;
  logic [DQ_W-1:0] dq;

  // A lane driven by the module wins; an idle lane reads as zero.
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      if (dq_d_oe[i]) begin
        dq[i*sdcs_pkg::LANE_W +: sdcs_pkg::LANE_W] = dq_d[i*sdcs_pkg::LANE_W +: sdcs_pkg::LANE_W];
      end else if (dq_c_oe) begin
        dq[i*sdcs_pkg::LANE_W +: sdcs_pkg::LANE_W] = dq_c[i*sdcs_pkg::LANE_W +: sdcs_pkg::LANE_W];
      end else begin
        dq[i*sdcs_pkg::LANE_W +: sdcs_pkg::LANE_W] = '0;
      end
    end
  end

  modport ctrl (output cke, cmd, ba, a, dqm, dq_c, dq_c_oe, input dq);
  modport dev (input cke, cmd, ba, a, dqm, dq, output dq_d, dq_d_oe);
endinterface

// ==== verilog/sdcs_pkg.sv ====
/*
  Shared constants and types for the registered SDRAM command spacing pair.
  Assumes a single 10 MHz system clock shared by controller and module.
*/
package sdcs_pkg;

  // Clock and bus geometry.
  localparam int CLK_PERIOD_NS = 100;
  localparam int DQ_W = 64;
  localparam int LANE_W = 8;
  localparam int BA_W = 2;
  localparam int A_W = 12;
  localparam int AP_BIT = 10;
  localparam int MR_CL_LSB = 4;
  localparam int MR_BL_LSB = 0;

  // Least times round up to whole cycles, never below one.
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Core array timings in ns, us and ms, the refresh row count and derived cycle counts.
  localparam int RCD_NS = 20;
  localparam int RP_NS = 20;
  localparam int RFC_NS = 70;
  localparam int RCD_CYC = min_cycles(RCD_NS);
  localparam int RP_CYC = min_cycles(RP_NS);
  localparam int RFC_CYC = min_cycles(RFC_NS);
  localparam int POWERUP_US = 100;
  localparam int POWERUP_CYC = min_cycles(POWERUP_US * 1000);
  localparam int REF_PERIOD_MS = 64;
  localparam int REF_ROWS = 4096;
  localparam int REF_PERIOD_CYC = REF_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int REF_INT_CYC = REF_PERIOD_CYC / REF_ROWS;

  // Command spacing in clocks, and the wake-up refresh count.
  localparam int COLUMN_CMD_SPACING = 1;
  localparam int POWERDOWN_EXIT_LEAD = 1;
  localparam int POWERDOWN_ENTRY_LEAD = 1;
  localparam int MASK_TO_INPUT_DELAY = 0;
  localparam int WRITE_MASK_LATENCY = 0;
  localparam int READ_MASK_TO_HIZ = 2;
  localparam int WRITE_TO_DATA_DELAY = 0;
  localparam int WRITE_DATA_TO_ACTIVATE_CL3 = 5;
  localparam int WRITE_DATA_TO_ACTIVATE_CL2 = 4;
  localparam int DATA_TO_PRECHARGE = 2;
  localparam int DATA_TO_BURST_STOP = 1;
  localparam int DATA_TO_COLUMN = 1;
  localparam int LMR_GAP_MIN = 2;
  localparam int LMR_GAP_SAFE = 3;
  localparam int REG_LATENCY = 1;
  localparam int WAKE_REFRESHES = 2;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0, CMD_ACT = 3'h1, CMD_RD = 3'h2, CMD_WR = 3'h3,
    CMD_PRE = 3'h4, CMD_REF = 3'h5, CMD_LMR = 3'h6, CMD_BST = 3'h7
  } sdcs_cmd_e;

  typedef enum logic [1:0] {
    CL3_GRADE = 2'h0, FAST_CL2_GRADE = 2'h1, SLOW_CL2_GRADE = 2'h2
  } sdcs_grade_e;

  function automatic int grade_cl(input sdcs_grade_e g);
    return (g == CL3_GRADE) ? 3 : 2;
  endfunction

  function automatic int write_data_to_activate(input sdcs_grade_e g);
    return (g == CL3_GRADE) ? WRITE_DATA_TO_ACTIVATE_CL3 : WRITE_DATA_TO_ACTIVATE_CL2;
  endfunction

endpackage
